// File: design/flash_housekeeping_pkg.sv
// Constants shared by the flash housekeeping command block.
package flash_housekeeping_pkg;

  // ************************************************************
  // Command opcodes
  // ************************************************************
  localparam logic [7:0] OP_RESUME_A = 8'h7a;
  localparam logic [7:0] OP_RESUME_B = 8'h30;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET_EXEC = 8'h99;
  localparam logic [7:0] OP_NULL = 8'h00;
  localparam logic [7:0] OP_UID_READ = 8'h4b;
  localparam logic [7:0] OP_TABLE_READ = 8'h5a;

  // ************************************************************
  // Frame layout and status positions
  // ************************************************************
  localparam logic [2:0] BYTE_IDX_ADDR_LOW = 3'h3;
  localparam logic [2:0] BYTE_IDX_DATA = 3'h5;
  localparam int STAT_WIP_POS = 0;
  localparam int STAT_WEL_POS = 1;
  localparam int STAT_ERASE_SUSP_POS = 10;
  localparam int STAT_PROG_SUSP_POS = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // ************************************************************
  // Parameter table header bytes
  // ************************************************************
  localparam logic [7:0] TBL_LAST_ADDR = 8'h17;
  localparam logic [7:0] TBL_FILL = 8'hff;
  localparam logic [7:0] SIG_B0 = 8'h53;
  localparam logic [7:0] SIG_B1 = 8'h46;
  localparam logic [7:0] SIG_B2 = 8'h44;
  localparam logic [7:0] SIG_B3 = 8'h50;
  localparam logic [7:0] REV_MINOR = 8'h00;
  localparam logic [7:0] REV_MAJOR = 8'h01;
  localparam logic [7:0] HDR_COUNT = 8'h01;
  localparam logic [7:0] HDR0_ID = 8'h00;
  localparam logic [7:0] HDR0_LEN = 8'h09;
  localparam logic [7:0] HDR0_PTR = 8'h30;
  localparam logic [7:0] HDR1_LEN = 8'h03;
  localparam logic [7:0] HDR1_PTR = 8'h60;
  localparam logic [7:0] PTR_UPPER = 8'h00;

endpackage

// File: design/flash_housekeeping.sv
// Housekeeping command block: resume, null, software reset, unique id, parameter table.
`timescale 1ns/1ps
`default_nettype none
module flash_housekeeping
  import flash_housekeeping_pkg::*;
#(
  // Arbitrary value; each part carries its own factory identifier.
  parameter logic [127:0] UNIQUE_ID = 128'h0123456789abcdef_fedcba9876543210,
  // Arbitrary value standing in for the maker code.
  parameter logic [7:0] MAKER_CODE = 8'h5c
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so_ff,
  output logic so_oe_ff,
  input wire logic suspend_program_evt,
  input wire logic suspend_erase_evt,
  input wire logic op_start_evt,
  input wire logic op_complete_evt,
  output logic [15:0] status_bits_ff,
  output logic op_running_ff,
  output logic resume_pulse_ff,
  output logic abort_op_ff,
  output logic soft_reset_pulse_ff
);

  // ************************************************************
  // Elaboration checks on the shared layout constants
  // ************************************************************
  if (STAT_PROG_SUSP_POS > 15 || STAT_ERASE_SUSP_POS > 15 ||
      STAT_WEL_POS > 15 || STAT_WIP_POS > 15) begin : g_bad_status_pos
    $error("Status flag position lies outside the status word.");
  end
  if (BYTE_IDX_DATA <= BYTE_IDX_ADDR_LOW) begin : g_bad_frame_layout
    $error("Data phase must follow the low address byte.");
  end

  // ************************************************************
  // Link domain: byte framing on the serial clock
  // ************************************************************
  logic [6:0] shift_ff;
  logic [2:0] bit_cnt_ff;
  logic [2:0] byte_cnt_ff;
  logic [7:0] opcode_ff;
  logic [7:0] addr_ff;
  logic [7:0] data_cnt_ff;
  logic cmd_tgl_ff;
  logic [7:0] cmd_hold_ff;

  wire [7:0] full_byte = {shift_ff, si};
  wire byte_done = (bit_cnt_ff == 3'h7);
  wire at_opcode = (byte_cnt_ff == 3'h0);
  wire at_addr_low = (byte_cnt_ff == BYTE_IDX_ADDR_LOW);
  wire in_data = (byte_cnt_ff == BYTE_IDX_DATA);
  wire is_uid = (opcode_ff == OP_UID_READ);
  wire is_table = (opcode_ff == OP_TABLE_READ);
  wire data_phase = in_data && (is_uid || is_table);
  wire load_opcode = byte_done && at_opcode;
  wire load_addr = byte_done && at_addr_low;
  wire count_byte = byte_done && !in_data;
  wire count_data = byte_done && in_data;

  // The frame logic is cleared by deselect itself, since the serial clock stops between frames.
  // A frame cut in mid-byte therefore leaves nothing behind for the next one.
  // Input bits are taken on the rising edge, most significant bit first.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      shift_ff <= 7'h00;
      bit_cnt_ff <= 3'h0;
      byte_cnt_ff <= 3'h0;
      opcode_ff <= 8'h00;
      addr_ff <= 8'h00;
      data_cnt_ff <= 8'h00;
    end else begin
      shift_ff <= full_byte[6:0];
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      if (load_opcode) begin
        opcode_ff <= full_byte;
      end
      if (load_addr) begin
        addr_ff <= full_byte;
      end
      if (count_byte) begin
        byte_cnt_ff <= byte_cnt_ff + 3'h1;
      end
      if (count_data) begin
        data_cnt_ff <= data_cnt_ff + 8'h01;
      end
    end
  end

  // ************************************************************
  // Link domain: opcode hand-off to the core
  // ************************************************************
  // The toggle and the held opcode survive deselect, so the core sees every command once
  // and still reads a steady opcode after the frame has ended. Reset reaches them while
  // the serial clock is idle, so its release needs no synchroniser on this side.
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      cmd_tgl_ff <= 1'b0;
      cmd_hold_ff <= 8'h00;
    end else if (!cs_n && load_opcode) begin
      cmd_tgl_ff <= ~cmd_tgl_ff;
      cmd_hold_ff <= full_byte;
    end
  end

  // ************************************************************
  // Link domain: read data selection
  // ************************************************************
  // Bytes past the header area read as fill; the table bodies are served elsewhere.
  function automatic logic [7:0] table_byte(input logic [7:0] a, input logic [7:0] maker);
    logic [7:0] v;
    v = TBL_FILL;
    case (a)
      8'h00: v = SIG_B0;
      8'h01: v = SIG_B1;
      8'h02: v = SIG_B2;
      8'h03: v = SIG_B3;
      8'h04: v = REV_MINOR;
      8'h05: v = REV_MAJOR;
      8'h06: v = HDR_COUNT;
      8'h08: v = HDR0_ID;
      8'h09: v = REV_MINOR;
      8'h0a: v = REV_MAJOR;
      8'h0b: v = HDR0_LEN;
      8'h0c: v = HDR0_PTR;
      8'h0d: v = PTR_UPPER;
      8'h0e: v = PTR_UPPER;
      8'h10: v = maker;
      8'h11: v = REV_MINOR;
      8'h12: v = REV_MAJOR;
      8'h13: v = HDR1_LEN;
      8'h14: v = HDR1_PTR;
      8'h15: v = PTR_UPPER;
      8'h16: v = PTR_UPPER;
      default: v = TBL_FILL;
    endcase
    return v;
  endfunction

  wire [7:0] table_addr = addr_ff + data_cnt_ff;
  wire [7:0] table_data = table_byte(table_addr, MAKER_CODE);
  wire [2:0] msb_index = 3'h7 - bit_cnt_ff;
  wire [6:0] uid_index = 7'h7f - {data_cnt_ff[3:0], bit_cnt_ff};
  wire uid_bit = UNIQUE_ID[uid_index];
  wire table_bit = table_data[msb_index];
  wire nxt_so = is_uid ? uid_bit : table_bit;

  // Output bits change on the falling edge so the host samples them stable on the rising one.
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end else begin
      so_ff <= data_phase ? nxt_so : 1'b0;
      so_oe_ff <= data_phase;
    end
  end

  // ************************************************************
  // Core domain: command event crossing
  // ************************************************************
  logic tgl_meta_ff;
  logic tgl_sync_ff;
  logic tgl_seen_ff;
  logic [7:0] cmd_ff;
  logic cmd_valid_ff;

  // The held opcode stays put until the next frame's opcode, long after the toggle settles.
  // The valid strobe lasts one core cycle for each command byte received.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tgl_meta_ff <= 1'b0;
      tgl_sync_ff <= 1'b0;
      tgl_seen_ff <= 1'b0;
      cmd_ff <= 8'h00;
      cmd_valid_ff <= 1'b0;
    end else begin
      tgl_meta_ff <= cmd_tgl_ff;
      tgl_sync_ff <= tgl_meta_ff;
      tgl_seen_ff <= tgl_sync_ff;
      cmd_valid_ff <= tgl_sync_ff ^ tgl_seen_ff;
      cmd_ff <= cmd_hold_ff;
    end
  end

  // ************************************************************
  // Core domain: resume, null and software reset
  // ************************************************************
  logic armed_ff;
  logic wel_ff;
  logic wip_ff;
  logic prog_susp_ff;
  logic erase_susp_ff;

  wire cmd_resume = cmd_valid_ff && (cmd_ff == OP_RESUME_A || cmd_ff == OP_RESUME_B);
  wire cmd_arm = cmd_valid_ff && (cmd_ff == OP_RESET_ARM);
  wire cmd_exec = cmd_valid_ff && (cmd_ff == OP_RESET_EXEC) && armed_ff;
  wire any_susp = prog_susp_ff || erase_susp_ff;
  // Resume only counts while a suspend flag is up; otherwise it is ignored.
  wire do_resume = cmd_resume && any_susp;
  wire susp_evt = suspend_program_evt || suspend_erase_evt;
  // Aborting leaves the half-written data undefined; the array side must discard it.
  wire op_active = op_running_ff || wip_ff || any_susp;
  wire nxt_abort = cmd_exec && op_active;

  wire nxt_armed = cmd_valid_ff ? cmd_arm : armed_ff;
  wire nxt_wel = do_resume ? 1'b1 : ((susp_evt || op_complete_evt) ? 1'b0 :
                 (op_start_evt ? 1'b1 : wel_ff));
  wire nxt_wip = do_resume ? 1'b1 : ((susp_evt || op_complete_evt) ? 1'b0 :
                 (op_start_evt ? 1'b1 : wip_ff));
  wire nxt_prog_susp = suspend_program_evt ? 1'b1 : (do_resume ? 1'b0 : prog_susp_ff);
  wire nxt_erase_susp = suspend_erase_evt ? 1'b1 : (do_resume ? 1'b0 : erase_susp_ff);
  wire nxt_running = do_resume ? 1'b1 : ((susp_evt || op_complete_evt) ? 1'b0 :
                     (op_start_evt ? 1'b1 : op_running_ff));

  always_ff @(posedge core_clk) begin
    if (rst || cmd_exec) begin
      armed_ff <= 1'b0;
      wel_ff <= STATUS_RESET[STAT_WEL_POS];
      wip_ff <= STATUS_RESET[STAT_WIP_POS];
      prog_susp_ff <= STATUS_RESET[STAT_PROG_SUSP_POS];
      erase_susp_ff <= STATUS_RESET[STAT_ERASE_SUSP_POS];
      op_running_ff <= 1'b0;
    end else begin
      armed_ff <= nxt_armed;
      wel_ff <= nxt_wel;
      wip_ff <= nxt_wip;
      // Suspend sets win over a resume clear in the same cycle.
      prog_susp_ff <= nxt_prog_susp;
      erase_susp_ff <= nxt_erase_susp;
      op_running_ff <= nxt_running;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_bits_ff <= STATUS_RESET;
      resume_pulse_ff <= 1'b0;
      abort_op_ff <= 1'b0;
      soft_reset_pulse_ff <= 1'b0;
    end else begin
      status_bits_ff <= STATUS_RESET;
      status_bits_ff[STAT_WIP_POS] <= wip_ff;
      status_bits_ff[STAT_WEL_POS] <= wel_ff;
      status_bits_ff[STAT_ERASE_SUSP_POS] <= erase_susp_ff;
      status_bits_ff[STAT_PROG_SUSP_POS] <= prog_susp_ff;
      resume_pulse_ff <= do_resume;
      abort_op_ff <= nxt_abort;
      soft_reset_pulse_ff <= cmd_exec;
    end
  end

endmodule
`default_nettype wire

// File: tb/flash_host_model.sv
// Host serial bus model that frames commands and reads data back.
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so_ff
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // suspends come long after a resume, and no program runs inside a suspended erase.
  task automatic start();
    #7;
    cs_n = 1'b0;
    #40;
  endtask
  task automatic send(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      si = v[i];
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
  endtask
  task automatic recv(output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      si = ~si;
      #40 sclk = 1'b1;
      v[i] = so_ff;
      #40 sclk = 1'b0;
    end
  endtask
  task automatic stop();
    #40 cs_n = 1'b1;
    si = ~si;
    #80;
  endtask
endmodule
`default_nettype wire

// File: tb/flash_housekeeping_chk.sv
// Concurrent checks on the ports of the housekeeping block.
`timescale 1ns/1ps
`default_nettype none
module flash_housekeeping_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic so_ff,
  input wire logic so_oe_ff,
  input wire logic suspend_program_evt,
  input wire logic [15:0] status_bits_ff,
  input wire logic op_running_ff,
  input wire logic resume_pulse_ff,
  input wire logic abort_op_ff,
  input wire logic soft_reset_pulse_ff
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_resume_sets_flags: assert property (
    $rose(resume_pulse_ff) |-> ##[0:1] status_bits_ff[1:0] == 2'b11)
    else $error("resume left flags clear");
  a_resume_clears_susp: assert property (
    resume_pulse_ff |-> op_running_ff ##1 !status_bits_ff[15] && !status_bits_ff[10])
    else $error("resume left suspend set");
  a_resume_needs_susp: assert property (
    $rose(resume_pulse_ff) |-> status_bits_ff[15] || status_bits_ff[10])
    else $error("resume without suspend");
  a_suspend_sets_bit: assert property (suspend_program_evt |-> ##2 status_bits_ff[15])
    else $error("program suspend bit not set");
  a_reset_clears_all: assert property (
    soft_reset_pulse_ff |-> !op_running_ff ##1 status_bits_ff == 16'h0000)
    else $error("soft reset left state");
  a_abort_when_running: assert property (
    soft_reset_pulse_ff && $past(op_running_ff) |-> abort_op_ff)
    else $error("running op not aborted");
  a_abort_needs_reset: assert property (abort_op_ff |-> soft_reset_pulse_ff)
    else $error("abort without soft reset");
  a_oe_off_deselect: assert property (cs_n |-> !so_oe_ff)
    else $error("output enabled while deselected");
  a_so_idle_low: assert property (!so_oe_ff |-> !so_ff)
    else $error("data out not low when idle");
  c_resume: cover property (resume_pulse_ff);
  c_abort: cover property (abort_op_ff);
  c_read: cover property ($rose(so_oe_ff));
endmodule
bind flash_housekeeping flash_housekeeping_chk u_chk (
  .core_clk(core_clk), .rst(rst), .cs_n(cs_n),
  .so_ff(so_ff), .so_oe_ff(so_oe_ff), .suspend_program_evt(suspend_program_evt),
  .status_bits_ff(status_bits_ff), .op_running_ff(op_running_ff),
  .resume_pulse_ff(resume_pulse_ff), .abort_op_ff(abort_op_ff),
  .soft_reset_pulse_ff(soft_reset_pulse_ff));
`default_nettype wire

// File: tb/test_flash_housekeeping.sv
// Self-checking bench for the housekeeping command block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module test_flash_housekeeping
  import flash_housekeeping_pkg::*;
;
  // Arbitrary identifier and maker values.
  localparam logic [127:0] UID = 128'h5a5a0f0f3c3ca5a5_123456789abcdef0;
  localparam logic [7:0] MAKER = 8'h3c;
  logic [7:0] tbl [0:23] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hff,
    8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff,
    MAKER, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hff};
  logic core_clk = 1'b0;
  logic rst;
  logic [3:0] evts = 4'h0;
  wire logic sclk, cs_n, si, so_ff, so_oe, op_running_ff;
  wire logic resume_p, abort_p, reset_p;
  wire logic [15:0] status_bits_ff;
  logic [15:0] sts = 16'h0000;
  logic run = 1'b0;
  logic armed = 1'b0;
  logic [7:0] b, ad;
  logic [23:0] a;
  int errors = 0;
  int samples_checked = 0;
  int n_resume = 0, n_abort = 0, n_reset = 0;
  int exp_resume = 0, exp_abort = 0, exp_reset = 0;
  flash_housekeeping #(.UNIQUE_ID(UID), .MAKER_CODE(MAKER)) u_flash_housekeeping (
    .core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si), .so_ff(so_ff),
    .so_oe_ff(so_oe), .suspend_program_evt(evts[0]), .suspend_erase_evt(evts[1]),
    .op_start_evt(evts[2]), .op_complete_evt(evts[3]), .status_bits_ff(status_bits_ff),
    .op_running_ff(op_running_ff), .resume_pulse_ff(resume_p), .abort_op_ff(abort_p),
    .soft_reset_pulse_ff(reset_p));
  flash_host_model u_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so_ff(so_ff));
  // Counts each one-cycle pulse of the core side.
  always @(posedge core_clk) begin
    if (resume_p === 1'b1) n_resume++;
    if (abort_p === 1'b1) n_abort++;
    if (reset_p === 1'b1) n_reset++;
  end
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Pulses one core event: 0 program suspend, 1 erase suspend, 2 start, 3 complete.
  task automatic evt(input int i);
    @(posedge core_clk) evts <= 4'h1 << i;
    @(posedge core_clk) evts <= 4'h0;
    repeat (4) @(posedge core_clk);
    if (i < 2) sts = (sts & 16'hfffc) | (i == 1 ? 16'h0400 : 16'h8000);
    else if (i == 2) sts = sts | 16'h0003;
    else sts = sts & 16'hfffc;
    run = (i == 2);
  endtask
  task automatic cmd(input logic [7:0] op);
    u_host.start();
    u_host.send(op);
    u_host.stop();
    repeat (6) @(posedge core_clk);
    if (op == OP_RESET_EXEC && armed) begin
      if (run || (sts & 16'h8401) != 0) exp_abort++;
      exp_reset++;
      sts = 16'h0000;
      run = 1'b0;
    end
    if ((op == OP_RESUME_A || op == OP_RESUME_B) && (sts & 16'h8400) != 0) begin
      exp_resume++;
      sts = (sts | 16'h0003) & 16'h7bff;
      run = 1'b1;
    end
    armed = (op == OP_RESET_ARM);
  endtask
  task automatic chk_st();
    `CHK(status_bits_ff, sts)
    `CHK(op_running_ff, run)
    `CHK(n_resume, exp_resume)
    `CHK(n_abort, exp_abort)
    `CHK(n_reset, exp_reset)
  endtask
  initial begin
    #2_000_000;
    errors++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h21b8));
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    cmd(OP_NULL);
    for (int t = 0; t < 4; t++) begin
      a = (t == 0) ? 24'h0 : {16'($urandom), 8'($urandom_range(0, 31))};
      u_host.start();
      u_host.send(OP_TABLE_READ);
      for (int k = 2; k >= 0; k--) u_host.send(a[k*8 +: 8]);
      u_host.send(8'($urandom));
      for (int j = 0; j < (t == 0 ? 25 : 6); j++) begin
        u_host.recv(b);
        if (j == 0) `CHK(so_oe, 1'b1)
        ad = 8'(a[7:0] + j);
        `CHK(b, (ad <= 8'h17) ? tbl[ad[4:0]] : 8'hff)
      end
      u_host.stop();
      `CHK(so_oe, 1'b0)
    end
    $display("table read test done");
    u_host.start();
    u_host.send(OP_UID_READ);
    repeat (4) u_host.send(8'($urandom));
    for (int j = 0; j < 17; j++) begin
      u_host.recv(b);
      `CHK(b, UID[127 - 8 * (j % 16) -: 8])
    end
    u_host.stop();
    `CHK(so_oe, 1'b0)
    $display("unique id test done");
    cmd(OP_RESUME_A);
    chk_st();
    for (int k = 0; k < 2; k++) begin
      evt(2);
      evt(k);
      chk_st();
      cmd(OP_NULL);
      chk_st();
      cmd(k == 1 ? OP_RESUME_B : OP_RESUME_A);
      chk_st();
    end
    evt(3);
    chk_st();
    $display("resume test done");
    evt(2);
    evt(0);
    cmd(OP_RESET_EXEC);
    chk_st();
    cmd(OP_RESET_ARM);
    cmd(OP_NULL);
    cmd(OP_RESET_EXEC);
    chk_st();
    cmd(OP_RESET_ARM);
    cmd(OP_RESET_EXEC);
    chk_st();
    evt(2);
    cmd(OP_RESET_ARM);
    cmd(OP_RESET_EXEC);
    chk_st();
    $display("reset test done");
    print_verdict();
  end
endmodule
`default_nettype wire
